// [logic/spic_pkg.sv]
// spic_pkg: shared constants and types of the serial command front end.
// assumes: included before every spic_* module; no registers reachable by software.

package spic_pkg;

   // ********************************************************************
   // instruction byte layout
   // ********************************************************************
   localparam int OPC_MSB = 7;
   localparam int OPC_LSB = 5;
   localparam int ARG_MSB = 4;
   localparam int ARG_LSB = 0;
   localparam int BYTE_W = 8;
   localparam int ARG_W = 5;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // fixed arguments of buffer and system instructions
   localparam logic [4:0] ARG_BUFFER = 5'h1A;
   localparam logic [4:0] ARG_SOFT_RESET = 5'h1F;

   // ********************************************************************
   // reset values and sizes
   // ********************************************************************
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [4:0] ADDR_ZERO = 5'h00;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;

   // ********************************************************************
   // timing
   // ********************************************************************
   localparam int CLK_PERIOD_NS = 10;
   // longest time an outside read source may take to present data
   localparam int RD_RESP_NS = 30;
   localparam int RD_RESP_CYCLES = (RD_RESP_NS / CLK_PERIOD_NS) < 1 ? 1 : (RD_RESP_NS / CLK_PERIOD_NS);

   // ********************************************************************
   // types
   // ********************************************************************
   typedef enum logic [2:0] {
      OPC_READ_CTRL  = 3'b000,
      OPC_READ_BUF   = 3'b001,
      OPC_WRITE_CTRL = 3'b010,
      OPC_WRITE_BUF  = 3'b011,
      OPC_BIT_SET    = 3'b100,
      OPC_BIT_CLEAR  = 3'b101,
      OPC_UNUSED     = 3'b110,
      OPC_SYSTEM     = 3'b111
   } spic_opcode_t;

   // kind of control register update handed to the register file
   typedef enum logic [1:0] {
      UPD_WRITE = 2'b00,
      UPD_SET   = 2'b01,
      UPD_CLEAR = 2'b10,
      UPD_NONE  = 2'b11
   } spic_upd_t;

   typedef struct packed {
      spic_upd_t kind;
      logic [4:0] addr;
      logic [7:0] data;
   } spic_reg_cmd_t;

   typedef enum logic [2:0] {
      ST_OPCODE   = 3'b000,
      ST_RD_CTRL  = 3'b001,
      ST_RD_BUF   = 3'b010,
      ST_WR_CTRL  = 3'b011,
      ST_WR_BUF   = 3'b100,
      ST_IGNORE   = 3'b101
   } spic_state_t;

endpackage

// [logic/spic_fifo.sv]
// spic_fifo: small synchronous FIFO with a registered output word.
// assumes: one clock, asynchronous active-high reset, valid/ready on both sides.

`timescale 1ns/1ps
`default_nettype none

module spic_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   logic load_out;

   // ********************************************************************
   // flags and handshakes
   // ********************************************************************
   assign in_ready = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign push = in_valid & in_ready;
   // refill the output word whenever it is empty or being taken
   assign load_out = (count != '0) & (~out_valid | out_ready);
   assign pop = load_out;

   // storage array
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // registered output word
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         out_data <= '0;
         out_valid <= 1'b0;
      end else begin
         if (load_out) begin
            out_data <= mem[rd_ptr];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// [logic/spic_cmd_if.sv]
// spic_cmd_if: serial command decoder of a network controller, link side slave.
// assumes: host drives sck, cs_n, si from outside the clk_sys domain; sck is well
// below clk_sys/8; control registers and buffer memory live outside this module.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - only clock mode 0,0, clock idles low, nothing selectable
// R2 - input bits taken on each rising serial clock edge
// R3 - output line changes only on falling serial clock edges
// R4 - host keeps select low through an operation, raises it after
// R5 - first byte holds 3-bit opcode then 5-bit argument
// R6 - writes and bit ops carry data bytes; reads and reset carry none
// R7 - seven opcodes decoded: 000,001,010,011,100,101,111
// R8 - soft reset is one all-ones byte touching no register
// R9 - read address picks one of 32 registers of current bank
// R10 - general register read shifts out at once, MSB first
// R11 - media or management register read sends one dummy byte first
// R12 - read lasts until select rises, output driven meanwhile
// R13 - physical-layer registers not reachable by register read
// R14 - nothing host-visible happens except by received instruction
// R15 - buffer read and write need argument 1Ah
// R16 - system instruction argument must be 1Fh
// R17 - write byte cut short by select rising is dropped
// R18 - bit set ORs data into general registers only
// R19 - opcode byte arrives MSB first, opcode in bits 7..5
// R20 - select high returns decoder to idle for a new opcode
module spic_cmd_if (
   input wire logic clk_sys,
   input wire logic rst,
   // serial link pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   // control register file
   output spic_pkg::spic_reg_cmd_t reg_cmd,
   output logic reg_cmd_valid,
   output logic [4:0] reg_rd_addr,
   input wire logic [7:0] reg_rd_data,
   input wire logic addr_is_mac_mii,
   // buffer memory read stream
   output logic buf_rd_req,
   input wire logic [7:0] buf_rd_data,
   // buffer memory write stream
   output logic [7:0] buf_wr_data,
   output logic buf_wr_valid,
   input wire logic buf_wr_ready,
   output logic buf_wr_overflow,
   // system
   output logic soft_reset
);
   import spic_pkg::*;

   logic sck_q1;
   logic sck_q2;
   logic sck_q3;
   logic cs_q1;
   logic cs_q2;
   logic si_q1;
   logic si_q2;
   logic sck_rise;
   logic sck_fall;
   logic selected;
   spic_state_t state;
   spic_state_t next_state;
   logic [2:0] bit_cnt;
   logic [6:0] rx;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [7:0] tx;
   logic load_pending;
   logic dummy_pending;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;
   spic_opcode_t opc;
   logic [4:0] arg;

   // ********************************************************************
   // pin synchronisers and edge detection
   // ********************************************************************
   // two flops per pin, a third on sck; edges are found from the second and third stage only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sck_q1 <= 1'b0;
         sck_q2 <= 1'b0;
         sck_q3 <= 1'b0;
         cs_q1 <= 1'b1;
         cs_q2 <= 1'b1;
         si_q1 <= 1'b0;
         si_q2 <= 1'b0;
      end else begin
         sck_q1 <= sck;
         sck_q2 <= sck_q1;
         sck_q3 <= sck_q2;
         cs_q1 <= cs_n;
         cs_q2 <= cs_q1;
         si_q1 <= si;
         si_q2 <= si_q1;
      end
   end

   // mode 0,0 only: capture on rise, launch on fall, no polarity choice (see R1)
   assign selected = ~cs_q2;
   assign sck_rise = selected & sck_q2 & ~sck_q3; // see R2
   assign sck_fall = selected & ~sck_q2 & sck_q3; // see R3

   // ********************************************************************
   // receive shifter
   // ********************************************************************
   // bits enter MSB first, so the opcode lands in bits 7..5 (see R19)
   assign rx_byte = {rx, si_q2};
   assign byte_done = sck_rise & (bit_cnt == BIT_LAST);
   assign opc = spic_opcode_t'(rx_byte[OPC_MSB:OPC_LSB]); // see R5
   assign arg = rx_byte[ARG_MSB:ARG_LSB];

   // bit counter restarts whenever select is high, so a partial byte is lost
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bit_cnt <= BIT_ZERO;
         rx <= '0;
      end else if (!selected) begin
         bit_cnt <= BIT_ZERO; // see R17
      end else if (sck_rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         rx <= rx_byte[6:0];
      end
   end

   // ********************************************************************
   // instruction decoder
   // ********************************************************************
   // next state on completion of the opcode byte
   always_comb begin
      next_state = state;
      if (byte_done && state == ST_OPCODE) begin
         unique case (opc) // see R7
            OPC_READ_CTRL: begin
               next_state = ST_RD_CTRL;
            end
            OPC_READ_BUF: begin
               next_state = (arg == ARG_BUFFER) ? ST_RD_BUF : ST_IGNORE; // see R15
            end
            OPC_WRITE_CTRL, OPC_BIT_SET, OPC_BIT_CLEAR: begin
               next_state = ST_WR_CTRL; // see R6
            end
            OPC_WRITE_BUF: begin
               next_state = (arg == ARG_BUFFER) ? ST_WR_BUF : ST_IGNORE; // see R15
            end
            OPC_UNUSED, OPC_SYSTEM: begin
               next_state = ST_IGNORE; // see R8
            end
         endcase
      end
   end

   // state and latched instruction; select high always returns to opcode phase
   spic_upd_t upd_kind;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ST_OPCODE;
         reg_rd_addr <= ADDR_ZERO;
         upd_kind <= UPD_NONE;
      end else if (!selected) begin
         state <= ST_OPCODE; // see R20
      end else begin
         state <= next_state;
         if (byte_done && state == ST_OPCODE) begin
            reg_rd_addr <= arg; // see R9
            unique case (opc)
               OPC_WRITE_CTRL: begin
                  upd_kind <= UPD_WRITE;
               end
               OPC_BIT_SET: begin
                  upd_kind <= UPD_SET;
               end
               OPC_BIT_CLEAR: begin
                  upd_kind <= UPD_CLEAR;
               end
               default: begin
                  upd_kind <= UPD_NONE;
               end
            endcase
         end
      end
   end

   // soft reset pulse once the all-ones byte has fully arrived
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= byte_done && state == ST_OPCODE && opc == OPC_SYSTEM && arg == ARG_SOFT_RESET; // see R16
      end
   end

   // ********************************************************************
   // control register updates
   // ********************************************************************
   // only a whole data byte reaches the register file; set and clear are
   // refused on media and management addresses since they are not general
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_cmd <= '{kind: UPD_NONE, addr: ADDR_ZERO, data: BYTE_ZERO};
         reg_cmd_valid <= 1'b0;
      end else begin
         reg_cmd_valid <= 1'b0;
         if (byte_done && state == ST_WR_CTRL) begin // see R17
            reg_cmd <= '{kind: upd_kind, addr: reg_rd_addr, data: rx_byte};
            reg_cmd_valid <= (upd_kind == UPD_WRITE) | ~addr_is_mac_mii; // see R18
         end
      end
   end

   // ********************************************************************
   // buffer write stream through the FIFO
   // ********************************************************************
   // the host cannot be stalled; a byte arriving while the previous one still waits
   // at the full FIFO replaces it and the loss is flagged, so the drain side must keep up on average
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fifo_in_valid <= 1'b0;
         fifo_in_data <= BYTE_ZERO;
         buf_wr_overflow <= 1'b0;
      end else begin
         buf_wr_overflow <= 1'b0;
         if (byte_done && state == ST_WR_BUF) begin // see R17
            fifo_in_data <= rx_byte;
            fifo_in_valid <= 1'b1;
            buf_wr_overflow <= fifo_in_valid & ~fifo_in_ready;
         end else if (fifo_in_ready) begin
            fifo_in_valid <= 1'b0;
         end
      end
   end

   spic_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_data(fifo_in_data),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(buf_wr_data),
      .out_valid(buf_wr_valid),
      .out_ready(buf_wr_ready)
   );

   // ********************************************************************
   // transmit path
   // ********************************************************************
   // ask for the next buffer byte at each completed byte, before the falling edge that launches it; the
   // requests come only from host traffic, never from the block itself
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         buf_rd_req <= 1'b0;
      end else begin
         buf_rd_req <= byte_done && ((state == ST_OPCODE && next_state == ST_RD_BUF) || state == ST_RD_BUF); // see R14
      end
   end

   // a load is armed at each completed byte of a read, and served at the next
   // falling edge, several clk_sys cycles later, when outside data is stable;
   // the media test waits for that fall because the address is only latched
   // in the very cycle the opcode byte completes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         load_pending <= 1'b0;
         dummy_pending <= 1'b0;
      end else if (!selected) begin
         load_pending <= 1'b0;
         dummy_pending <= 1'b0;
      end else if (byte_done && (next_state == ST_RD_CTRL || next_state == ST_RD_BUF)) begin
         load_pending <= 1'b1;
         if (state == ST_OPCODE) begin
            dummy_pending <= (next_state == ST_RD_CTRL); // see R11
         end
      end else if (sck_fall) begin
         load_pending <= 1'b0;
         dummy_pending <= 1'b0;
      end
   end

   // output shifter: MSB leaves first, new bit placed on each falling edge;
   // a general register reloads every byte until select rises
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx <= BYTE_ZERO;
      end else if (sck_fall) begin // see R3
         if (load_pending && dummy_pending && addr_is_mac_mii) begin
            tx <= BYTE_ZERO; // see R11
         end else if (load_pending && state == ST_RD_CTRL) begin
            tx <= reg_rd_data; // see R10
         end else if (load_pending && state == ST_RD_BUF) begin
            tx <= buf_rd_data;
         end else begin
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // output driven during a read for as long as select stays low, not during the opcode byte (see R12)
   assign so = tx[7];
   assign so_oe = selected & (state == ST_RD_CTRL || state == ST_RD_BUF);

   // physical-layer registers have no address here; only the 32 bank
   // addresses reach the register file (see R13)

endmodule

`default_nettype wire

// [verif/spic_cmd_if_sva.sv]
// spic_cmd_if_sva: port-level checks of the serial command decoder.
// assumes: bound to spic_cmd_if; host keeps an sck half period of at least 4 clk_sys.
`timescale 1ns/1ps
`default_nettype none
module spic_cmd_if_chk
   import spic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic so,
   input wire logic so_oe,
   input wire spic_reg_cmd_t reg_cmd,
   input wire logic reg_cmd_valid,
   input wire logic [4:0] reg_rd_addr,
   input wire logic addr_is_mac_mii,
   input wire logic buf_rd_req,
   input wire logic [7:0] buf_wr_data,
   input wire logic buf_wr_valid,
   input wire logic buf_wr_ready,
   input wire logic soft_reset
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ****************************************************************
   // properties
   // ****************************************************************
   // six samples high: select synchroniser has surely caught up
   sequence s_idle;
      cs_n [*6];
   endsequence
   sequence s_one_pulse_cmd;
      reg_cmd_valid ##1 !reg_cmd_valid;
   endsequence
   property p_idle_quiet;
      s_idle |-> !so_oe && !reg_cmd_valid && !buf_rd_req && !soft_reset;
   endproperty
   property p_so_on_fall;
      so_oe && $past(so_oe) && $changed(so) |-> !sck;
   endproperty
   property p_cmd_pulse;
      reg_cmd_valid |-> !cs_n && reg_cmd.kind != UPD_NONE && reg_cmd.addr == reg_rd_addr ##0 s_one_pulse_cmd;
   endproperty
   property p_bitop_general;
      reg_cmd_valid && (reg_cmd.kind == UPD_SET || reg_cmd.kind == UPD_CLEAR) |-> !addr_is_mac_mii;
   endproperty
   property p_soft_pulse;
      soft_reset |-> !cs_n && !reg_cmd_valid ##1 !soft_reset;
   endproperty
   property p_rd_req_spacing;
      buf_rd_req |=> !buf_rd_req [*8];
   endproperty
   property p_oe_selected;
      $rose(so_oe) |-> !cs_n;
   endproperty
   property p_wr_hold;
      buf_wr_valid && !buf_wr_ready |=> buf_wr_valid && $stable(buf_wr_data);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("activity while deselected");
   a_so_on_fall: assert property (p_so_on_fall) else $error("so moved while sck high");
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("bad register command pulse");
   a_bitop_general: assert property (p_bitop_general) else $error("bit op on media register");
   a_soft_pulse: assert property (p_soft_pulse) else $error("bad soft reset pulse");
   a_rd_req_spacing: assert property (p_rd_req_spacing) else $error("buffer requests too close");
   a_oe_selected: assert property (p_oe_selected) else $error("so driven while deselected");
   a_wr_hold: assert property (p_wr_hold) else $error("write word dropped before ready");
endmodule
bind spic_cmd_if spic_cmd_if_chk u_chk (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .so(so),
   .so_oe(so_oe), .reg_cmd(reg_cmd), .reg_cmd_valid(reg_cmd_valid), .reg_rd_addr(reg_rd_addr),
   .addr_is_mac_mii(addr_is_mac_mii), .buf_rd_req(buf_rd_req), .buf_wr_data(buf_wr_data),
   .buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready), .soft_reset(soft_reset));
`default_nettype wire

// [verif/spic_host_model.sv]
// spic_host_model: serial link master that frames instructions for the decoder.
// assumes: called by hierarchical task calls from the bench; 125 ns link period.
`timescale 1ns/1ps
`default_nettype none
module spic_host_model (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so
);
   localparam real HALF = 62.5;
   // ****************************************************************
   // link tasks
   // ****************************************************************
   // clock idles low, frame closed at time zero
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   task automatic start();
      cs_n = 1'b0;
      #HALF;
   endtask
   // data set up while sck low, bits taken at the rise, msb first
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         si = tx[i];
         #HALF sck = 1'b1;
         rx[i] = so;
         #HALF sck = 1'b0;
      end
   endtask
   // released data line flips so a stale bit is never mistaken for a held one
   task automatic stop();
      #HALF cs_n = 1'b1;
      si = ~si;
      #200;
   endtask
endmodule
`default_nettype wire

// [verif/tb_spic_cmd_if.sv]
// tb_spic_cmd_if: self-checking bench for the serial command decoder.
// assumes: register file and buffer memory are modelled here; FIFO drained by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_spic_cmd_if;
   import spic_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic buf_wr_ready = 1'b1;
   logic sck, cs_n, si, so, so_oe, reg_cmd_valid, buf_rd_req, buf_wr_valid, buf_wr_overflow, soft_reset;
   logic [4:0] reg_rd_addr;
   logic [7:0] reg_rd_data, buf_rd_data, buf_wr_data, rx;
   logic [7:0] bval = 8'h3C;
   logic addr_is_mac_mii;
   spic_reg_cmd_t reg_cmd, last_cmd;
   int mismatches = 0;
   int n_compared = 0;
   int n_reg = 0, n_soft = 0, n_ovf = 0, n0 = 0, s0 = 0;
   logic [7:0] wr_q[$];
   wire logic so_line = so_oe ? so : 1'bz;
   always #5 clk_sys = ~clk_sys;
   // register file: contents derived from address, 10h..17h are media registers
   assign reg_rd_data = {3'b101, reg_rd_addr};
   assign addr_is_mac_mii = (reg_rd_addr[4:3] == 2'b10);
   assign buf_rd_data = bval;
   // ****************************************************************
   // monitors
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (buf_rd_req) bval <= bval + 8'h01;
      if (reg_cmd_valid) begin
         n_reg++;
         last_cmd <= reg_cmd;
      end
      if (soft_reset) n_soft++;
      if (buf_wr_overflow) n_ovf++;
      if (buf_wr_valid && buf_wr_ready) wr_q.push_back(buf_wr_data);
   end
   spic_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
   spic_cmd_if u_dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .reg_cmd(reg_cmd), .reg_cmd_valid(reg_cmd_valid), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
      .addr_is_mac_mii(addr_is_mac_mii), .buf_rd_req(buf_rd_req), .buf_rd_data(buf_rd_data),
      .buf_wr_data(buf_wr_data), .buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready),
      .buf_wr_overflow(buf_wr_overflow), .soft_reset(soft_reset));
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic frame2(input logic [7:0] b0, input logic [7:0] b1);
      n0 = n_reg;
      s0 = n_soft;
      u_host.start();
      u_host.xfer(b0, 8, rx);
      u_host.xfer(b1, 8, rx);
      u_host.stop();
   endtask
   task automatic stop_test();
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_write_ctrl();
      frame2(8'h43, 8'h5A);
      check(8'(n_reg - n0), 8'h01);
      check({3'h0, last_cmd.addr}, 8'h03);
      check({6'h00, last_cmd.kind}, {6'h00, UPD_WRITE});
      check(last_cmd.data, 8'h5A);
   endtask
   // set and clear on a general and on a media register
   task automatic t_bit_ops();
      logic [2:0] op;
      logic [4:0] a;
      for (int k = 0; k < 4; k++) begin
         op = (k < 2) ? OPC_BIT_SET : OPC_BIT_CLEAR;
         a = k[0] ? 5'h12 : 5'h05;
         frame2({op, a}, 8'h96);
         check(8'(n_reg - n0), k[0] ? 8'h00 : 8'h01);
         if (!k[0]) check({6'h00, last_cmd.kind}, (k < 2) ? 8'h01 : 8'h02);
      end
   endtask
   // select rising mid byte drops it, next frame decodes afresh
   task automatic t_abort();
      n0 = n_reg;
      u_host.start();
      u_host.xfer(8'h47, 8, rx);
      u_host.xfer(8'hA0, 5, rx);
      u_host.stop();
      check(8'(n_reg - n0), 8'h00);
      frame2(8'h47, 8'h11);
      check(8'(n_reg - n0), 8'h01);
      check(last_cmd.data, 8'h11);
   endtask
   task automatic t_read_ctrl(input logic [4:0] a);
      u_host.start();
      u_host.xfer({OPC_READ_CTRL, a}, 8, rx);
      if (a[4:3] == 2'b10) begin
         u_host.xfer(8'h00, 8, rx);
         check(rx, 8'h00);
      end
      u_host.xfer(8'h00, 8, rx);
      check(rx, {3'b101, a});
      u_host.xfer(8'h00, 8, rx);
      check(rx, {3'b101, a});
      u_host.stop();
   endtask
   task automatic t_buf_read();
      logic [7:0] e;
      e = bval;
      u_host.start();
      u_host.xfer({OPC_READ_BUF, ARG_BUFFER}, 8, rx);
      u_host.xfer(8'h00, 8, rx);
      check(rx, e + 8'h01);
      u_host.xfer(8'h00, 8, rx);
      check(rx, e + 8'h02);
      u_host.stop();
   endtask
   // wrong argument ignored, then fill past refusal while stalled, then drain
   task automatic t_buf_write();
      frame2({OPC_WRITE_BUF, 5'h00}, 8'h55);
      repeat (10) @(negedge clk_sys);
      check(8'(wr_q.size()), 8'h00);
      @(negedge clk_sys) buf_wr_ready = 1'b0;
      u_host.start();
      u_host.xfer({OPC_WRITE_BUF, ARG_BUFFER}, 8, rx);
      for (int i = 0; i < FIFO_DEPTH + 3; i++) u_host.xfer(8'(i), 8, rx);
      u_host.stop();
      check(8'(n_ovf != 0), 8'h01);
      @(negedge clk_sys) buf_wr_ready = 1'b1;
      repeat (40) @(negedge clk_sys);
      check(8'(wr_q.size() >= FIFO_DEPTH), 8'h01);
      for (int i = 0; i < FIFO_DEPTH; i++) check(wr_q[i], 8'(i));
   endtask
   task automatic t_system();
      n0 = n_reg;
      s0 = n_soft;
      u_host.start();
      u_host.xfer(8'hFF, 8, rx);
      u_host.stop();
      check(8'(n_soft - s0), 8'h01);
      check(8'(n_reg - n0), 8'h00);
      frame2({OPC_SYSTEM, 5'h10}, 8'h00);
      check(8'(n_soft - s0), 8'h00);
      frame2({OPC_UNUSED, 5'h05}, 8'h33);
      check(8'(n_reg - n0 + n_soft - s0), 8'h00);
   endtask
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      repeat (6) @(negedge clk_sys);
      t_write_ctrl();
      t_bit_ops();
      t_abort();
      t_read_ctrl(5'h02);
      t_read_ctrl(5'h13);
      t_buf_read();
      t_buf_write();
      t_system();
      stop_test();
   end
   // normal run stays well under 20k cycles, so this only fires on a hang
   initial begin
      #400_000;
      mismatches++;
      stop_test();
   end
endmodule
`default_nettype wire
